// ### src/swi_core.sv
// Interrupt-enable flags, standby control and wake logic of the CPU.
// Assumes the decoder supplies event strobes; external pins arrive asynchronously.
`timescale 1ns/1ps
module swi_core
    import swi_pkg::*;
(
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic clk_en,
    input wire swi_cpu_evt_t evt,
    input wire swi_io_req_t io_req,
    input wire logic io_stop_a,
    input wire logic bus_request_n,
    input wire logic unmaskable_irq_n,
    input wire logic [SWI_NUM_IRQ-1:0] maskable_irq_n,
    output logic [7:0] io_rdata,
    output logic io_hit,
    output logic global_irq_enable,
    output logic saved_irq_enable,
    output logic parity_overflow_flag,
    output logic parity_overflow_load,
    output logic [SWI_NUM_IRQ-1:0] irq_take,
    output logic nmi_take,
    output logic standby_active,
    output logic osc_run,
    output logic clock_out_en,
    output logic clk_div1,
    output logic [3:0] low_drive,
    output logic bus_release,
    output logic bus_grant_n,
    output logic bus_drive_high,
    output logic resume_after_sleep,
    output logic opcode_fetch_gate,
    output logic [7:0] return_from_interrupt_first_tstates,
    output logic core_stall
);
    logic [7:0] cpu_control;
    logic [7:0] int_vector_low;
    logic [7:0] int_trap_control;
    logic [1:0] bus_request_sync;
    logic [1:0] nmi_sync;
    logic [SWI_NUM_IRQ-1:0] irq_meta;
    logic [SWI_NUM_IRQ-1:0] irq_sync;
    logic nmi_prev;
    logic nmi_latched;
    logic bus_wake;
    logic [SWI_STAB_WIDTH-1:0] stab_count;
    swi_state_t state;

    logic [7:0] next_cpu_control;
    logic [7:0] next_int_vector_low;
    logic [7:0] next_int_trap_control;
    logic next_global;
    logic next_saved;
    logic next_parity;
    logic next_nmi_latched;
    logic next_bus_wake;
    logic [SWI_STAB_WIDTH-1:0] next_stab_count;
    swi_state_t next_state;

    logic breq;
    logic nmi_fall;
    logic [SWI_NUM_IRQ-1:0] irq_enabled;
    logic irq_wake;
    logic m1_output_enable;

    // Two-stage synchronisers; only the second stage feeds logic
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            bus_request_sync <= 2'h3;
            nmi_sync <= 2'h3;
            irq_meta <= '1;
            irq_sync <= '1;
            nmi_prev <= 1'b1;
        end
        else if (clk_en)
        begin
            bus_request_sync <= {bus_request_sync[0], bus_request_n};
            nmi_sync <= {nmi_sync[0], unmaskable_irq_n};
            irq_meta <= maskable_irq_n;
            irq_sync <= irq_meta;
            nmi_prev <= nmi_sync[1];
        end
    end

    assign breq = ~bus_request_sync[1];
    assign nmi_fall = nmi_prev & ~nmi_sync[1];

    // Per-source enables; only the low three trap-control bits are enables
    genvar gi;
    generate
        for (gi = 0; gi < SWI_NUM_IRQ; gi = gi + 1)
        begin : g_irq
            assign irq_enabled[gi] = ~irq_sync[gi] & int_trap_control[gi];
            assign irq_take[gi] = irq_enabled[gi] & global_irq_enable & (state == SWI_RUN);
        end
    endgenerate

    assign irq_wake = |irq_enabled;
    assign nmi_take = nmi_latched & (state == SWI_RUN);

    // Stand-in for the operation-mode register bit; legacy peripherals want it clear
    assign m1_output_enable = 1'b0;

    always_comb
    begin
        next_cpu_control = cpu_control;
        next_int_vector_low = int_vector_low;
        next_int_trap_control = int_trap_control;
        if (io_req.wr && state == SWI_RUN)
        begin
            unique case (io_req.addr)
                SWI_ADDR_CPU_CONTROL: next_cpu_control = io_req.wdata & SWI_CPU_CONTROL_MASK;
                SWI_ADDR_VECTOR_LOW:
                    next_int_vector_low = io_req.wdata & SWI_VECTOR_LOW_MASK;
                SWI_ADDR_TRAP_CONTROL:
                    next_int_trap_control = (int_trap_control & ~SWI_TRAP_CONTROL_WMASK)
                        | (io_req.wdata & SWI_TRAP_CONTROL_WMASK);
                default: ;
            endcase
        end
        if (evt.trap)
        begin
            next_int_trap_control[SWI_BIT_TRAP] = 1'b1;
        end
    end

    // Flag state; priority follows decoder strobe exclusivity
    always_comb
    begin
        next_global = global_irq_enable;
        next_saved = saved_irq_enable;
        next_parity = parity_overflow_flag;
        if (evt.unmask)
        begin
            next_global = 1'b1;
            next_saved = 1'b1;
        end
        else if (evt.mask_all || evt.maskable_accept)
        begin
            next_global = 1'b0;
            next_saved = 1'b0;
        end
        else if (evt.nmi_accept)
        begin
            next_saved = global_irq_enable;
            next_global = 1'b0;
        end
        else if (evt.nmi_return)
        begin
            next_global = saved_irq_enable;
        end
        if (evt.ld_a_vec_or_refresh)
        begin
            next_parity = saved_irq_enable;
        end
    end

    // Standby sequencing
    always_comb
    begin
        next_state = state;
        next_stab_count = stab_count;
        next_bus_wake = bus_wake;
        next_nmi_latched = nmi_latched;
        if (nmi_fall)
        begin
            next_nmi_latched = 1'b1;
        end
        else if (evt.nmi_accept)
        begin
            next_nmi_latched = 1'b0;
        end
        unique case (state)
            SWI_RUN:
            begin
                if (evt.sleep_second_byte && cpu_control[SWI_BIT_STANDBY_EN] && io_stop_a)
                begin
                    next_state = SWI_STANDBY;
                end
            end
            SWI_STANDBY:
            begin
                if (nmi_latched || nmi_fall || irq_wake
                    || (breq && cpu_control[SWI_BIT_BUS_REQUEST_WAKE]))
                begin
                    next_state = SWI_STABILISE;
                    next_stab_count = SWI_STAB_COUNT;
                    next_bus_wake = ~(nmi_latched | nmi_fall | irq_wake);
                end
            end
            SWI_STABILISE:
            begin
                if (stab_count > 20'h00001)
                begin
                    next_stab_count = stab_count - 20'h00001;
                end
                else if (bus_wake)
                begin
                    next_state = SWI_BUS_HELD;
                end
                else if (nmi_latched || irq_wake)
                begin
                    next_state = SWI_RESUME;
                end
                else
                begin
                    next_state = SWI_STANDBY;
                end
            end
            SWI_BUS_HELD:
            begin
                if (!breq)
                begin
                    next_state = SWI_STANDBY;
                    next_bus_wake = 1'b0;
                end
            end
            SWI_RESUME:
            begin
                next_state = SWI_RUN;
            end
            default: next_state = SWI_RUN;
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            // Reset also restarts clocks from standby; core fetches from the reset vector
            cpu_control <= SWI_CPU_CONTROL_RESET;
            int_vector_low <= SWI_VECTOR_LOW_RESET;
            int_trap_control <= SWI_TRAP_CONTROL_RESET;
            global_irq_enable <= 1'b0;
            saved_irq_enable <= 1'b0;
            parity_overflow_flag <= 1'b0;
            nmi_latched <= 1'b0;
            bus_wake <= 1'b0;
            stab_count <= '0;
            state <= SWI_RUN;
        end
        else if (clk_en)
        begin
            cpu_control <= next_cpu_control;
            int_vector_low <= next_int_vector_low;
            int_trap_control <= next_int_trap_control;
            global_irq_enable <= next_global;
            saved_irq_enable <= next_saved;
            parity_overflow_flag <= next_parity;
            nmi_latched <= next_nmi_latched;
            bus_wake <= next_bus_wake;
            stab_count <= next_stab_count;
            state <= next_state;
        end
    end

    always_comb
    begin
        io_hit = io_req.rd && (io_req.addr == SWI_ADDR_CPU_CONTROL
            || io_req.addr == SWI_ADDR_VECTOR_LOW || io_req.addr == SWI_ADDR_TRAP_CONTROL);
        io_rdata = 8'h00;
        if (io_req.addr == SWI_ADDR_CPU_CONTROL)
        begin
            io_rdata = cpu_control;
        end
        else if (io_req.addr == SWI_ADDR_VECTOR_LOW)
        begin
            io_rdata = int_vector_low;
        end
        else if (io_req.addr == SWI_ADDR_TRAP_CONTROL)
        begin
            io_rdata = int_trap_control;
        end
    end

    assign parity_overflow_load = evt.ld_a_vec_or_refresh;
    assign standby_active = (state == SWI_STANDBY);
    assign osc_run = (state != SWI_STANDBY);
    assign clock_out_en = (state == SWI_RUN) || (state == SWI_RESUME)
        || (state == SWI_BUS_HELD);
    assign core_stall = (state != SWI_RUN);
    assign clk_div1 = cpu_control[SWI_BIT_CLK_DIV];
    assign low_drive = {cpu_control[SWI_BIT_LN_CLOCK], cpu_control[SWI_BIT_LN_IO],
        cpu_control[SWI_BIT_LN_CPU], cpu_control[SWI_BIT_LN_ADDR]};
    // Bus stays released while request holds, whatever ended standby
    assign bus_release = breq && (state == SWI_BUS_HELD || state == SWI_RUN
        || state == SWI_RESUME);
    assign bus_grant_n = ~bus_release;
    assign bus_drive_high = (state == SWI_STANDBY);
    assign resume_after_sleep = (state == SWI_RESUME) && !global_irq_enable
        && !nmi_latched;
    assign opcode_fetch_gate = m1_output_enable | evt.return_from_interrupt_pair_fetched;
    // The decoder stretches the first refetch cycle; 22 T-states over 10 M-cycles overall
    assign return_from_interrupt_first_tstates = SWI_RETURN_FROM_INTERRUPT_FIRST_TSTATES;

    a_flag_unmask: assert property (@(posedge sys_clk) disable iff (srst)
        clk_en && evt.unmask |=> global_irq_enable && saved_irq_enable)
        else $error("unmask did not set both flags");
    a_nmi_save: assert property (@(posedge sys_clk) disable iff (srst)
        clk_en && evt.nmi_accept && !evt.unmask && !evt.mask_all && !evt.maskable_accept
        |=> !global_irq_enable && saved_irq_enable == $past(global_irq_enable))
        else $error("nmi flag save wrong");
    a_nmi_return: assert property (@(posedge sys_clk) disable iff (srst)
        clk_en && evt.nmi_return && !evt.unmask && !evt.mask_all && !evt.maskable_accept
        && !evt.nmi_accept |=> global_irq_enable == $past(saved_irq_enable)
        && $stable(saved_irq_enable))
        else $error("nmi return restore wrong");
    a_mask_clear: assert property (@(posedge sys_clk) disable iff (srst)
        clk_en && evt.maskable_accept && !evt.unmask |=> !global_irq_enable && !saved_irq_enable)
        else $error("maskable accept did not clear flags");
    a_irq_block: assert property (@(posedge sys_clk) disable iff (srst)
        !global_irq_enable |-> irq_take == '0)
        else $error("maskable taken while disabled");
    a_standby_entry: assert property (@(posedge sys_clk) disable iff (srst)
        clk_en && state == SWI_RUN && evt.sleep_second_byte && io_stop_a
        && cpu_control[SWI_BIT_STANDBY_EN] |=> standby_active && !osc_run)
        else $error("standby not entered");
    a_bus_request_gate: assert property (@(posedge sys_clk) disable iff (srst)
        state == SWI_STANDBY && !cpu_control[SWI_BIT_BUS_REQUEST_WAKE] && !nmi_latched && !nmi_fall
        && !irq_wake |=> state == SWI_STANDBY)
        else $error("woke without enabled source");
    a_stab_hold: assert property (@(posedge sys_clk) disable iff (srst)
        $rose(state == SWI_STABILISE) |-> stab_count == SWI_STAB_COUNT && !clock_out_en)
        else $error("stabilisation count not loaded");
    a_nmi_latch: assert property (@(posedge sys_clk) disable iff (srst)
        clk_en && nmi_fall && !evt.nmi_accept |=> nmi_latched)
        else $error("nmi edge not latched");
    a_divide_reset: assert property (@(posedge sys_clk)
        srst |=> !clk_div1)
        else $error("clock divide not cleared by reset");
endmodule // swi_core

// ### pkg/swi_pkg.sv
// Constants, register layout and shared types of the standby, wake and interrupt-enable block.
// Assumes a CPU core that reports decoded instruction events as one-cycle strobes.
// Behaviour
// - Return-from-interrupt opcode pair is refetched; first-byte cycle lasts four T-states.
// - Whole return-from-interrupt sequence takes 22 T-states over 10 machine cycles.
// - With m1_output_enable clear, opcode_fetch_gate shows only during that refetch.
// - int_trap_control answers I/O address 34H, int_vector_low answers 33H.
// - Global enable low blocks all maskable interrupts; nonmaskable and trap pass.
// - Nonmaskable accept copies global into saved enable, then clears global.
// - Nonmaskable return copies saved back into global, saved unchanged.
// - Reset and maskable accept clear both flags; return and trap leave them.
// - Loading accumulator from vector or refresh register copies saved flag to parity.
// - Standby entered after sleep second byte when control bit 6 and io stop set.
// - Standby stops oscillator, internal clocks and clock output.
// - Interrupt or bus-request wake restarts oscillator and counts 2^19 before resuming.
// - Reset held long enough leaves standby; clocks resume; execution restarts at 0000H.
// - With wake bit 5 set, bus request wakes, then bus is released and granted.
// - Withdrawn bus request after such wake reclaims bus, drives high, re-enters standby.
// - Reset or interrupt exit keeps bus released while the request stays active.
// - Nonmaskable falling edge is latched and ends standby even if released early.
// - A maskable source disabled in int_trap_control never ends standby.
// - An enabled maskable source ends standby; acknowledge if global enable, else continue.
// - Control bit 7 selects clock divide, reset to 0; bits 4,2,1,0 reduce drive.
package swi_pkg;
    localparam logic [7:0] SWI_ADDR_CPU_CONTROL = 8'h1F;
    localparam logic [7:0] SWI_ADDR_VECTOR_LOW = 8'h33;
    localparam logic [7:0] SWI_ADDR_TRAP_CONTROL = 8'h34;
    localparam logic [7:0] SWI_CPU_CONTROL_RESET = 8'h00;
    localparam logic [7:0] SWI_CPU_CONTROL_MASK = 8'hF7;
    localparam logic [7:0] SWI_VECTOR_LOW_RESET = 8'h00;
    localparam logic [7:0] SWI_VECTOR_LOW_MASK = 8'hE0;
    localparam logic [7:0] SWI_TRAP_CONTROL_RESET = 8'h39;
    localparam logic [7:0] SWI_TRAP_CONTROL_WMASK = 8'h07;
    localparam int SWI_BIT_CLK_DIV = 7;
    localparam int SWI_BIT_STANDBY_EN = 6;
    localparam int SWI_BIT_BUS_REQUEST_WAKE = 5;
    localparam int SWI_BIT_LN_CLOCK = 4;
    localparam int SWI_BIT_LN_IO = 2;
    localparam int SWI_BIT_LN_CPU = 1;
    localparam int SWI_BIT_LN_ADDR = 0;
    localparam int SWI_BIT_TRAP = 7;
    localparam int SWI_NUM_IRQ = 3;
    localparam int SWI_STAB_WIDTH = 20;
    localparam logic [19:0] SWI_STAB_COUNT = 20'h80000;
    localparam int SWI_RETURN_FROM_INTERRUPT_TSTATES = 22;
    localparam int SWI_RETURN_FROM_INTERRUPT_MCYCLES = 10;
    localparam logic [7:0] SWI_RETURN_FROM_INTERRUPT_FIRST_TSTATES = 8'h04;
    localparam logic [15:0] SWI_RESET_VECTOR = 16'h0000;

    typedef enum logic [2:0] {
        SWI_RUN,
        SWI_STANDBY,
        SWI_STABILISE,
        SWI_BUS_HELD,
        SWI_RESUME
    } swi_state_t;

    // One-cycle strobes from the instruction decoder
    typedef struct packed {
        logic unmask;
        logic mask_all;
        logic nmi_accept;
        logic nmi_return;
        logic maskable_accept;
        logic ret_irq;
        logic trap;
        logic ld_a_vec_or_refresh;
        logic sleep_second_byte;
        logic return_from_interrupt_pair_fetched;
    } swi_cpu_evt_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } swi_io_req_t;
endpackage

// ### dv/swi_far_side.sv
// Model of the bus master and interrupting peripherals beside the block.
// Assumes the bench sets request levels; pins move just after a clock edge.
`timescale 1ns/1ps
module swi_far_side
    import swi_pkg::*;
(
    input wire logic sys_clk,
    input wire logic want_bus,
    input wire logic want_nmi,
    input wire logic [SWI_NUM_IRQ-1:0] want_irq,
    output logic bus_request_n,
    output logic unmaskable_irq_n,
    output logic [SWI_NUM_IRQ-1:0] maskable_irq_n
);
    // Requests stay as levels until withdrawn, so a wake is never lost early
    always_ff @(posedge sys_clk)
    begin
        bus_request_n <= ~want_bus;
        unmaskable_irq_n <= ~want_nmi;
        maskable_irq_n <= ~want_irq;
    end
endmodule // swi_far_side

// ### dv/tb_top.sv
// Self-checking bench for the standby, wake and interrupt-enable block.
// Assumes the 2^19 stabilise wait cannot be shortened, so wakes are seen only starting.
`timescale 1ns/1ps
`define CHK(nm, ex, got) check_val(nm, 32'(ex), 32'(got))
module tb_top
    import swi_pkg::*;
;
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic clk_en = 1'b1;
    swi_cpu_evt_t evt = '0;
    swi_io_req_t io_req = '0;
    logic io_stop_a = 1'b0;
    logic want_bus = 1'b0;
    logic want_nmi = 1'b0;
    logic [2:0] want_irq = 3'h0;
    logic bus_request_n, unmaskable_irq_n;
    logic [2:0] maskable_irq_n, irq_take;
    logic [7:0] io_rdata, return_from_interrupt_first_tstates;
    logic [3:0] low_drive;
    logic io_hit, global_irq_enable, saved_irq_enable, parity_overflow_flag;
    logic parity_overflow_load, nmi_take, standby_active, osc_run, clock_out_en;
    logic clk_div1, bus_release, bus_grant_n, bus_drive_high, resume_after_sleep;
    logic opcode_fetch_gate, core_stall;
    int n_fail = 0;
    int n_tests = 0;
    int cyc = 0;

    always #25 sys_clk = ~sys_clk;

    swi_far_side swi_far_side_i (.sys_clk(sys_clk), .want_bus(want_bus), .want_nmi(want_nmi),
        .want_irq(want_irq), .bus_request_n(bus_request_n),
        .unmaskable_irq_n(unmaskable_irq_n), .maskable_irq_n(maskable_irq_n));

    swi_core swi_core_i (.sys_clk(sys_clk), .srst(srst), .clk_en(clk_en), .evt(evt),
        .io_req(io_req), .io_stop_a(io_stop_a), .bus_request_n(bus_request_n),
        .unmaskable_irq_n(unmaskable_irq_n), .maskable_irq_n(maskable_irq_n),
        .io_rdata(io_rdata), .io_hit(io_hit), .global_irq_enable(global_irq_enable),
        .saved_irq_enable(saved_irq_enable), .parity_overflow_flag(parity_overflow_flag),
        .parity_overflow_load(parity_overflow_load), .irq_take(irq_take),
        .nmi_take(nmi_take), .standby_active(standby_active), .osc_run(osc_run),
        .clock_out_en(clock_out_en), .clk_div1(clk_div1), .low_drive(low_drive),
        .bus_release(bus_release), .bus_grant_n(bus_grant_n),
        .bus_drive_high(bus_drive_high), .resume_after_sleep(resume_after_sleep),
        .opcode_fetch_gate(opcode_fetch_gate), .return_from_interrupt_first_tstates(return_from_interrupt_first_tstates),
        .core_stall(core_stall));

    task automatic check_val(input string nm, input logic [31:0] ex, input logic [31:0] got);
        n_tests++;
        if (got !== ex)
        begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", nm, ex, got);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // A run far beyond the planned two hundred or so cycles means a hang
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 8000)
        begin
            n_fail++;
            give_verdict();
        end
    end

    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic do_reset(input int n);
        @(posedge sys_clk) srst <= 1'b1;
        repeat (n) @(posedge sys_clk);
        srst <= 1'b0;
        step(1);
    endtask

    // One decoder strobe; flags land at the edge that samples it
    task automatic fire(input logic [9:0] e);
        @(posedge sys_clk) evt <= swi_cpu_evt_t'(e);
        @(posedge sys_clk) evt <= '0;
        #1;
    endtask

    task automatic io_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk) io_req <= '{a, d, 1'b1, 1'b0};
        @(posedge sys_clk) io_req <= '0;
        #1;
    endtask

    task automatic io_rd(input logic [7:0] a, input logic [7:0] ex, input logic hit);
        @(posedge sys_clk) io_req <= '{a, 8'h00, 1'b0, 1'b1};
        #1;
        `CHK("io_rdata", ex, io_rdata);
        `CHK("io_hit", hit, io_hit);
        @(posedge sys_clk) io_req <= '0;
        #1;
    endtask

    task automatic t_regs();
        io_rd(SWI_ADDR_CPU_CONTROL, 8'h00, 1'b1);
        io_rd(SWI_ADDR_VECTOR_LOW, 8'h00, 1'b1);
        io_rd(SWI_ADDR_TRAP_CONTROL, 8'h39, 1'b1);
        io_rd(8'h20, 8'h00, 1'b0);
        io_wr(8'h1F, 8'hFF);
        io_rd(8'h1F, 8'hF7, 1'b1);
        `CHK("clk_div1", 1'b1, clk_div1);
        `CHK("low_drive", 4'hF, low_drive);
        io_wr(8'h33, 8'hFF);
        io_rd(8'h33, 8'hE0, 1'b1);
        io_wr(8'h34, 8'hF8);
        io_rd(8'h34, 8'h38, 1'b1);
        io_wr(8'h1F, 8'h00);
        `CHK("clk_div1", 1'b0, clk_div1);
        $display("test registers done");
    endtask

    task automatic t_flags();
        `CHK("global", 1'b0, global_irq_enable);
        fire(10'h200);
        `CHK("saved", 1'b1, saved_irq_enable);
        fire(10'h010);
        fire(10'h008);
        `CHK("global", 1'b1, global_irq_enable);
        io_rd(8'h34, 8'hB8, 1'b1);
        fire(10'h080);
        `CHK("global", 1'b0, global_irq_enable);
        `CHK("saved", 1'b1, saved_irq_enable);
        @(posedge sys_clk) evt <= swi_cpu_evt_t'(10'h004);
        #1;
        `CHK("pv_load", 1'b1, parity_overflow_load);
        fire(10'h000);
        `CHK("parity", 1'b1, parity_overflow_flag);
        fire(10'h040);
        `CHK("global", 1'b1, global_irq_enable);
        `CHK("saved", 1'b1, saved_irq_enable);
        fire(10'h020);
        `CHK("flags", 2'b00, {global_irq_enable, saved_irq_enable});
        fire(10'h004);
        `CHK("parity", 1'b0, parity_overflow_flag);
        fire(10'h200);
        fire(10'h100);
        `CHK("flags", 2'b00, {global_irq_enable, saved_irq_enable});
        `CHK("first_t", SWI_RETURN_FROM_INTERRUPT_FIRST_TSTATES, return_from_interrupt_first_tstates);
        `CHK("fetch_gate", 1'b0, opcode_fetch_gate);
        @(posedge sys_clk) evt <= swi_cpu_evt_t'(10'h001);
        #1;
        `CHK("fetch_gate", 1'b1, opcode_fetch_gate);
        @(posedge sys_clk) evt <= '0;
        // A strobe seen while the enable is low must leave the flags alone
        @(posedge sys_clk) clk_en <= 1'b0;
        fire(10'h200);
        `CHK("frozen", 2'b00, {global_irq_enable, saved_irq_enable});
        @(posedge sys_clk) clk_en <= 1'b1;
        $display("test flags done");
    endtask

    task automatic t_irq();
        io_wr(8'h34, 8'h01);
        fire(10'h200);
        @(posedge sys_clk) want_irq <= 3'h1;
        step(5);
        `CHK("irq_take", 3'h1, irq_take);
        fire(10'h100);
        `CHK("irq_take", 3'h0, irq_take);
        @(posedge sys_clk) want_irq <= 3'h0;
        step(4);
        // Nonmaskable edge is taken in run even with global enable low
        @(posedge sys_clk) want_nmi <= 1'b1;
        step(5);
        `CHK("nmi_take", 1'b1, nmi_take);
        fire(10'h080);
        `CHK("nmi_take", 1'b0, nmi_take);
        @(posedge sys_clk) want_nmi <= 1'b0;
        step(4);
        $display("test irq gate done");
    endtask

    task automatic sleep_now(input logic [7:0] ctl);
        io_wr(8'h1F, ctl);
        fire(10'h002);
    endtask

    task automatic t_standby();
        io_wr(8'h34, 8'h00);
        sleep_now(8'h40);
        `CHK("standby", 1'b0, standby_active);
        @(posedge sys_clk) io_stop_a <= 1'b1;
        sleep_now(8'h40);
        `CHK("standby", 1'b1, standby_active);
        `CHK("osc_clk", 2'b00, {osc_run, clock_out_en});
        `CHK("core_stall", 1'b1, core_stall);
        `CHK("drive_high", 1'b1, bus_drive_high);
        @(posedge sys_clk) want_irq <= 3'h7;
        step(8);
        `CHK("standby", 1'b1, standby_active);
        @(posedge sys_clk) want_bus <= 1'b1;
        step(8);
        `CHK("standby", 1'b1, standby_active);
        @(posedge sys_clk) want_irq <= 3'h0;
        do_reset(2);
        `CHK("standby", 1'b0, standby_active);
        `CHK("osc_run", 1'b1, osc_run);
        // Request still held: synchroniser needs one more edge after reset
        step(1);
        `CHK("bus_grant_n", 1'b0, bus_grant_n);
        @(posedge sys_clk) want_bus <= 1'b0;
        step(4);
        sleep_now(8'h60);
        @(posedge sys_clk) want_bus <= 1'b1;
        step(8);
        `CHK("osc_run", 1'b1, osc_run);
        `CHK("bus_grant_n", 1'b1, bus_grant_n);
        `CHK("clock_out_en", 1'b0, clock_out_en);
        `CHK("standby", 1'b0, standby_active);
        @(posedge sys_clk) want_bus <= 1'b0;
        do_reset(2);
        sleep_now(8'h40);
        @(posedge sys_clk) want_nmi <= 1'b1;
        step(2);
        @(posedge sys_clk) want_nmi <= 1'b0;
        step(8);
        `CHK("osc_run", 1'b1, osc_run);
        do_reset(2);
        $display("test standby done");
    endtask

    initial
    begin
        repeat (20) @(posedge sys_clk);
        srst <= 1'b0;
        step(1);
        t_regs();
        t_flags();
        t_irq();
        t_standby();
        give_verdict();
    end
endmodule // tb_top
